// [design/jtag_ir_dr_regs.svh]
/*
  constants for the scan instruction and test data registers:
  widths, instruction codes, capture pattern, id field positions.
  assumes inclusion by the package, the synchroniser, the main module and the bench.
*/
`ifndef JTAG_IR_DR_REGS_SVH
`define JTAG_IR_DR_REGS_SVH

// register widths
`define IR_W        4
`define ID_W        32
`define PIN_W       4
`define BSR_W       8
`define OFS_W       32
`define SYNC_W      14

// instruction codes
`define INS_EXTEST  4'h0
`define INS_SAMPLE  4'h1
`define INS_IDCODE  4'h2
`define INS_CLAMP   4'h3
`define INS_HIGHZ   4'h4
`define INS_OFS_RD  4'h7
`define INS_OFS_WR  4'h8
`define INS_BYPASS  4'hf

// fixed capture-ir pattern, low two bits are 01
`define IR_CAPTURE  4'h1
// instruction taken on test-logic-reset
`define IR_RESET    `INS_IDCODE

// id word field positions
`define ID_VER_LSB  28
`define ID_PART_LSB 12
`define ID_MFR_LSB  1
`define ID_BIT0     1'b1

// boundary cell split: low cells pins in, high cells pins out
`define BSR_OUT_LSB 4

`endif

// [design/jtag_ir_dr_pkg.sv]
/*
  types for the scan instruction and test data registers.
  assumes the constants header sits beside it.
*/
`include "jtag_ir_dr_regs.svh"

package jtag_ir_dr_pkg;

  // tap controller state flags, one bundle
  typedef struct packed {
    logic tlr;
    logic captureIr;
    logic shiftIr;
    logic updateIr;
    logic captureDr;
    logic shiftDr;
    logic updateDr;
  } tapState_t;

  // everything that crosses from the scan pins into the clock domain
  typedef struct packed {
    logic             tck;
    logic             tdi;
    logic             trstN;
    tapState_t        st;
    logic [`PIN_W-1:0] pinIn;
  } syncBundle_t;

  // data register chosen by the current instruction
  typedef enum logic [3:0] {
    SEL_BYPASS = 4'b0001,
    SEL_BSR    = 4'b0010,
    SEL_ID     = 4'b0100,
    SEL_OFS    = 4'b1000
  } sel_t;

endpackage

// [design/jtag_in_sync.sv]
/*
  two flip-flop synchroniser for the scan pin bundle.
  assumes inputs asynchronous to clock; first stage read only by second.
*/
`timescale 1ns/1ps
`include "jtag_ir_dr_regs.svh"

module jtag_in_sync (
  input  wire logic              clock,   // system clock
  input  wire logic              sys_rst, // async reset, high
  input  wire logic [`SYNC_W-1:0] din,    // raw pin levels
  output logic      [`SYNC_W-1:0] dout    // synchronised levels
);

  logic [`SYNC_W-1:0] stage1_q;
  logic [`SYNC_W-1:0] stage1_d;
  logic [`SYNC_W-1:0] stage2_q;
  logic [`SYNC_W-1:0] stage2_d;

  // next values of both stages
  always_comb begin
    stage1_d = din;
    stage2_d = stage1_q;
  end

  // register the two stages
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign dout = stage2_q;

endmodule

// [design/jtag_instruction_and_data_regs.sv]
/*
  scan port instruction register, decode and test data registers
  (bypass, boundary scan, identification, threshold offsets).
  assumes an outside tap controller on tck that supplies its state
  flags; tck is sampled by clock, so tck must be much slower than clock.
*/
//
// Overview of operation
// - four-bit instruction register selects one of sixteen codes
// - in shift-ir, instruction bits move from tdi toward tdo each rise
// - shifted instruction takes effect only at update-ir
// - instruction lsb sits nearest tdo and leaves first
// - all data registers share tdi and tdo, instruction picks one
// - unselected data registers stay still and disturb nothing
// - bypass is one stage, loaded with zero on capture-dr
// - read-only 32-bit id register selected by idcode
// - id word: version 31..28, part 27..12, maker 11..1
// - decode extest 0, sample 1, idcode 2, clamp 3, highz 4, bypass f
// - extest: boundary chain in path, drives outputs, captures inputs
// - sample: normal function, capture live pins, preload by shifting
// - idcode: normal function, id readable right after reset
// - clamp: outputs from boundary chain, bypass in path
// - highz: all outputs disabled, bypass in path
// - offset read instruction reads threshold offsets over scan path
// - offset write instruction writes threshold offsets over scan path
// - bypass: fully normal operation, one-bit bypass in path
// - capture-ir loads fixed pattern with low bits 01
// - update-ir latches instruction on falling tck edge
// - tap reset by trst or five tms-high rises before use
`timescale 1ns/1ps
`include "jtag_ir_dr_regs.svh"

module jtag_instruction_and_data_regs
  import jtag_ir_dr_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION = 4'h1,    // arbitrary value
  parameter logic [15:0] ID_PART    = 16'h0123, // arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h055  // arbitrary value
) (
  input  wire logic             clock,     // system clock, 10 MHz
  input  wire logic             sys_rst,   // async reset, high
  input  wire logic             tck,       // scan clock pin
  input  wire logic             tdi,       // scan data in pin
  input  wire logic             trstN,     // scan reset pin, low
  input  wire tapState_t        tapState,  // tap controller flags
  input  wire logic [`PIN_W-1:0] coreOut,  // functional output values
  input  wire logic [`PIN_W-1:0] coreOutEn, // functional output enables
  input  wire logic [`PIN_W-1:0] pinIn,    // input pin levels
  input  wire logic [`OFS_W-1:0] ofsCur,   // current {full, empty} offsets
  output logic                  tdo,       // scan data out
  output logic                  tdoEn,     // tdo driven
  output logic      [`PIN_W-1:0] pinOut,   // output pin values
  output logic      [`PIN_W-1:0] pinOutEn, // output pin enables
  output logic      [`OFS_W-1:0] ofsWrData, // offsets written by scan
  output logic                  ofsWrStb,  // one-cycle write pulse
  output logic      [`IR_W-1:0]  instrCur  // current instruction
);

  // instruction to data register choice, undefined codes fall to bypass
  function automatic sel_t decodeSel(input logic [`IR_W-1:0] ins);
    sel_t s;
    s = SEL_BYPASS;
    if (ins == `INS_EXTEST || ins == `INS_SAMPLE) begin
      s = SEL_BSR;
    end else if (ins == `INS_IDCODE) begin
      s = SEL_ID;
    end else if (ins == `INS_OFS_RD || ins == `INS_OFS_WR) begin
      s = SEL_OFS;
    end
    return s;
  endfunction

  // instructions that hand the output pins to the boundary chain
  function automatic logic drivesPins(input logic [`IR_W-1:0] ins);
    return (ins == `INS_EXTEST) || (ins == `INS_CLAMP);
  endfunction

  syncBundle_t       syncS;
  logic [`SYNC_W-1:0] syncRaw;
  logic              tckRise;
  logic              tckFall;
  logic              tapRst;
  sel_t              sel;
  logic [`ID_W-1:0]  idWord;
  logic              selLsb;

  logic              tckPrev_q, tckPrev_d;
  logic [`IR_W-1:0]  irShift_q, irShift_d;
  logic [`IR_W-1:0]  instr_q, instr_d;
  logic              bypass_q, bypass_d;
  logic [`ID_W-1:0]  idShift_q, idShift_d;
  logic [`BSR_W-1:0] bsrShift_q, bsrShift_d;
  logic [`BSR_W-1:0] bsrUpd_q, bsrUpd_d;
  logic [`OFS_W-1:0] ofsShift_q, ofsShift_d;
  logic [`OFS_W-1:0] ofsWr_q, ofsWr_d;
  logic              ofsStb_q, ofsStb_d;
  logic              tdo_q, tdo_d;
  logic              tdoEn_q, tdoEn_d;
  logic [`PIN_W-1:0] pinOut_q, pinOut_d;
  logic [`PIN_W-1:0] pinOutEn_q, pinOutEn_d;

  // all pin-domain inputs through two flops
  jtag_in_sync u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({tck, tdi, trstN, tapState, pinIn}),
    .dout    (syncRaw)
  );

  // edges of tck and the combined tap reset
  always_comb begin
    syncS   = syncBundle_t'(syncRaw);
    tckRise = syncS.tck & ~tckPrev_q;
    tckFall = ~syncS.tck & tckPrev_q;
    tapRst  = syncS.st.tlr | ~syncS.trstN;
    sel     = decodeSel(instr_q);
    idWord  = {ID_VERSION, ID_PART, ID_MAKER, `ID_BIT0};
  end

  // lsb of the data register in the path
  always_comb begin
    case (sel)
      SEL_BSR: selLsb = bsrShift_q[0];
      SEL_ID:  selLsb = idShift_q[0];
      SEL_OFS: selLsb = ofsShift_q[0];
      default: selLsb = bypass_q;
    endcase
  end

  // next state of instruction and data registers
  always_comb begin
    tckPrev_d  = syncS.tck;
    irShift_d  = irShift_q;
    instr_d    = instr_q;
    bypass_d   = bypass_q;
    idShift_d  = idShift_q;
    bsrShift_d = bsrShift_q;
    bsrUpd_d   = bsrUpd_q;
    ofsShift_d = ofsShift_q;
    ofsWr_d    = ofsWr_q;
    ofsStb_d   = 1'b0;
    tdo_d      = tdo_q;
    tdoEn_d    = tdoEn_q;
    if (tapRst) begin
      instr_d = `IR_RESET;
      tdoEn_d = 1'b0;
    end else begin
      if (tckRise) begin
        if (syncS.st.captureIr) begin
          irShift_d = `IR_CAPTURE;
        end else if (syncS.st.shiftIr) begin
          irShift_d = {syncS.tdi, irShift_q[`IR_W-1:1]};
        end
        // only the selected register moves
        if (syncS.st.captureDr) begin
          case (sel)
            SEL_BSR: bsrShift_d = {coreOut, syncS.pinIn};
            SEL_ID:  idShift_d = idWord;
            SEL_OFS: ofsShift_d = ofsCur;
            default: bypass_d = 1'b0;
          endcase
        end else if (syncS.st.shiftDr) begin
          case (sel)
            SEL_BSR: bsrShift_d = {syncS.tdi, bsrShift_q[`BSR_W-1:1]};
            SEL_ID:  idShift_d = {syncS.tdi, idShift_q[`ID_W-1:1]};
            SEL_OFS: ofsShift_d = {syncS.tdi, ofsShift_q[`OFS_W-1:1]};
            default: bypass_d = syncS.tdi;
          endcase
        end
      end
      if (tckFall) begin
        if (syncS.st.updateIr) begin
          instr_d = irShift_q;
        end
        if (syncS.st.updateDr && sel == SEL_BSR) begin
          bsrUpd_d = bsrShift_q;
        end
        if (syncS.st.updateDr && instr_q == `INS_OFS_WR) begin
          ofsWr_d  = ofsShift_q;
          ofsStb_d = 1'b1;
        end
        // tdo changes on the falling edge only
        if (syncS.st.shiftIr) begin
          tdo_d = irShift_q[0];
        end else if (syncS.st.shiftDr) begin
          tdo_d = selLsb;
        end
        tdoEn_d = syncS.st.shiftIr | syncS.st.shiftDr;
      end
    end
  end

  // pin control: normal, driven from chain, or all released
  always_comb begin
    pinOut_d   = coreOut;
    pinOutEn_d = coreOutEn;
    if (!tapRst) begin
      if (instr_q == `INS_HIGHZ) begin
        pinOutEn_d = '0;
      end else if (drivesPins(instr_q)) begin
        pinOut_d   = bsrUpd_q[`BSR_W-1:`BSR_OUT_LSB];
        pinOutEn_d = '1;
      end
    end
  end

  // register all state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tckPrev_q  <= 1'b0;
      irShift_q  <= `IR_CAPTURE;
      instr_q    <= `IR_RESET;
      bypass_q   <= 1'b0;
      idShift_q  <= '0;
      bsrShift_q <= '0;
      bsrUpd_q   <= '0;
      ofsShift_q <= '0;
      ofsWr_q    <= '0;
      ofsStb_q   <= 1'b0;
      tdo_q      <= 1'b0;
      tdoEn_q    <= 1'b0;
      pinOut_q   <= '0;
      pinOutEn_q <= '0;
    end else begin
      tckPrev_q  <= tckPrev_d;
      irShift_q  <= irShift_d;
      instr_q    <= instr_d;
      bypass_q   <= bypass_d;
      idShift_q  <= idShift_d;
      bsrShift_q <= bsrShift_d;
      bsrUpd_q   <= bsrUpd_d;
      ofsShift_q <= ofsShift_d;
      ofsWr_q    <= ofsWr_d;
      ofsStb_q   <= ofsStb_d;
      tdo_q      <= tdo_d;
      tdoEn_q    <= tdoEn_d;
      pinOut_q   <= pinOut_d;
      pinOutEn_q <= pinOutEn_d;
    end
  end

  // outputs straight from flops
  assign tdo       = tdo_q;
  assign tdoEn     = tdoEn_q;
  assign pinOut    = pinOut_q;
  assign pinOutEn  = pinOutEn_q;
  assign ofsWrData = ofsWr_q;
  assign ofsWrStb  = ofsStb_q;
  assign instrCur  = instr_q;

  // checks on the behaviour above
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ir_hold_a: assert property (
    $changed(instr_q) |->
      $past(tckFall && syncS.st.updateIr) || $past(tapRst))
    else $error("instruction changed outside update-ir");

  reset_idcode_a: assert property (
    tapRst |=> instr_q == `INS_IDCODE ##1 pinOutEn_q == $past(coreOutEn))
    else $error("tap reset did not restore idcode and pins");

  ir_capture_a: assert property (
    tckRise && syncS.st.captureIr && !tapRst |=> irShift_q[1:0] == 2'b01)
    else $error("capture-ir pattern wrong");

  ir_shift_a: assert property (
    tckRise && syncS.st.shiftIr && !syncS.st.captureIr && !tapRst |=>
      irShift_q == {$past(syncS.tdi), $past(irShift_q[`IR_W-1:1])})
    else $error("instruction shift wrong");

  tdo_lsb_a: assert property (
    tckFall && syncS.st.shiftIr && !tapRst |=>
      tdo_q == $past(irShift_q[0]) && tdoEn_q)
    else $error("tdo does not show instruction lsb");

  bypass_zero_a: assert property (
    tckRise && syncS.st.captureDr && sel == SEL_BYPASS && !tapRst |=>
      !bypass_q)
    else $error("bypass not captured as zero");

  id_capture_a: assert property (
    tckRise && syncS.st.captureDr && sel == SEL_ID && !tapRst |=>
      idShift_q == idWord && idShift_q[0])
    else $error("id word capture wrong");

  highz_off_a: assert property (
    instr_q == `INS_HIGHZ && !tapRst |=> pinOutEn_q == '0)
    else $error("outputs enabled under highz");

  clamp_hold_a: assert property (
    instr_q == `INS_CLAMP && !tapRst |=>
      pinOut_q == $past(bsrUpd_q[`BSR_W-1:`BSR_OUT_LSB]))
    else $error("clamp outputs not from boundary chain");

  bypass_normal_a: assert property (
    instr_q == `INS_BYPASS && !tapRst |=>
      pinOut_q == $past(coreOut) && pinOutEn_q == $past(coreOutEn))
    else $error("bypass disturbed normal outputs");

  ofs_write_a: assert property (
    ofsStb_q |-> ofsWr_q == $past(ofsShift_q) && $past(instr_q) == `INS_OFS_WR)
    else $error("offset write pulse without offset write");

  // main scenarios
  cover_ir_load_c: cover property (tckFall && syncS.st.updateIr && !tapRst);
  cover_id_read_c: cover property (
    tckRise && syncS.st.shiftDr && sel == SEL_ID);
  cover_extest_c:  cover property (instr_q == `INS_EXTEST ##1 pinOutEn_q == '1);
  cover_ofs_wr_c:  cover property (ofsStb_q);

endmodule

// [verification/tap_ctrl_model.sv]
/*
  scan controller model: drives tck, tdi, state flags and trstN.
  assumes the bench clock paces it, eight clocks to one tck period.
*/
`timescale 1ns/1ps

module tap_ctrl_model
  import jtag_ir_dr_pkg::*;
(
  input  wire logic clock, // bench clock
  input  wire logic tdo,   // scan data from device
  output tapState_t st,    // state flags
  output logic      tck,   // scan clock
  output logic      tdi,   // scan data to device
  output logic      trstN  // scan reset, low
);
  localparam tapState_t IDLE = '0;

  // start in scan reset with tck parked high
  initial begin
    st = IDLE;
    tck = 1'b1;
    tdi = 1'b0;
    trstN = 1'b0;
  end

  // scan reset pin level
  task automatic rst(input logic v);
    trstN = v;
  endtask

  // one tck period in state s: fall, then rise with tdo sampled
  task automatic cyc(input tapState_t s, input logic d, output logic q);
    st = s;
    tdi = d;
    tck = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // capture, n shifts lsb first, exit; tdi toggles when unused
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    tapState_t s;
    logic      q;
    dout = '0;
    s = IDLE;
    s.captureIr = ir;
    s.captureDr = !ir;
    cyc(s, ~tdi, q);
    s = IDLE;
    s.shiftIr = ir;
    s.shiftDr = !ir;
    for (int i = 0; i < n; i++) begin
      cyc(s, din[i], q);
      dout[i] = q;
    end
    cyc(IDLE, ~tdi, q);
  endtask

  // update state, then back to idle
  task automatic upd(input logic ir);
    tapState_t s;
    logic      q;
    s = IDLE;
    s.updateIr = ir;
    s.updateDr = !ir;
    cyc(s, ~tdi, q);
    cyc(IDLE, ~tdi, q);
  endtask

  // five rises with tms high reach test-logic-reset
  task automatic tapReset();
    tapState_t s;
    logic      q;
    s = IDLE;
    s.tlr = 1'b1;
    repeat (5) cyc(s, ~tdi, q);
    cyc(IDLE, ~tdi, q);
  endtask
endmodule

// [verification/tb.sv]
/*
  self-checking bench for the scan instruction and data registers.
  assumes the controller model carries all scan traffic.
*/
`timescale 1ns/1ps
`include "jtag_ir_dr_regs.svh"

module tb;
  import jtag_ir_dr_pkg::*;
  localparam logic [3:0]  VER  = 4'h5;    // arbitrary value
  localparam logic [15:0] PART = 16'h2b6e; // arbitrary value
  localparam logic [10:0] MAKR = 11'h2d1;  // arbitrary value
  logic        clock     = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [3:0]  coreOut   = 4'h9;
  logic [3:0]  coreOutEn = 4'h6;
  logic [3:0]  pinIn     = 4'hc;
  logic [31:0] ofsCur    = 32'h1234_0abc;
  logic        tck, tdi, trstN, tdo, tdoEn, ofsWrStb;
  tapState_t   st;
  logic [3:0]  pinOut, pinOutEn, instrCur, curIr;
  logic [31:0] ofsWrData, dout;
  int          n_errors, comparisons, nStb, nEn, k;

  jtag_instruction_and_data_regs #(.ID_VERSION(VER), .ID_PART(PART),
    .ID_MAKER(MAKR)) dut (.clock(clock), .sys_rst(sys_rst), .tck(tck),
    .tdi(tdi), .trstN(trstN), .tapState(st), .coreOut(coreOut),
    .coreOutEn(coreOutEn), .pinIn(pinIn), .ofsCur(ofsCur), .tdo(tdo),
    .tdoEn(tdoEn), .pinOut(pinOut), .pinOutEn(pinOutEn),
    .ofsWrData(ofsWrData), .ofsWrStb(ofsWrStb), .instrCur(instrCur));

  tap_ctrl_model ctrl (.clock(clock), .tdo(tdo), .st(st), .tck(tck),
    .tdi(tdi), .trstN(trstN));

  // 10 MHz clock
  always #50 clock = ~clock;

  // count strobe and tdo enable cycles, away from the launching edge
  always @(negedge clock) begin
    if (ofsWrStb === 1'b1)
      nStb++;
    if (tdoEn === 1'b1)
      nEn++;
  end

  // compare and report
  task automatic chk(input logic [31:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ir load of defined codes only, eight bits to see the shift path
  task automatic loadIr(input logic [3:0] c);
    ctrl.scan(1'b1, 8, {24'h0, c, 4'ha}, dout);
    chk(dout, 32'ha1, "ir capture and shift");
    chk(instrCur, curIr, "ir held before update");
    ctrl.upd(1'b1);
    curIr = c;
    chk(instrCur, c, "ir after update");
  endtask

  // bypass path: captured zero then tdi one stage late
  task automatic byp();
    ctrl.scan(1'b0, 8, 32'h96, dout);
    chk(dout, 32'h2c, "bypass path");
    ctrl.upd(1'b0);
  endtask

  // hang guard, about ten times the expected run
  initial begin
    #3000000;
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    curIr = `INS_IDCODE;
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk(instrCur, `INS_IDCODE, "reset instr");
    chk(tdoEn, 1'b0, "reset tdoEn");
    repeat (4) @(posedge clock);
    #1;
    ctrl.rst(1'b1);
    ctrl.tapReset();
    ctrl.scan(1'b0, 32, 32'h0, dout);
    chk(dout, {VER, PART, MAKR, 1'b1}, "id word");
    chk(pinOut, coreOut, "pins during id");
    ctrl.upd(1'b0);
    chk(nEn, 256, "tdo enable span");
    $display("test id done");
    loadIr(`INS_SAMPLE);
    ctrl.scan(1'b0, 8, 32'ha5, dout);
    chk(dout, {coreOut, pinIn}, "sample capture");
    ctrl.upd(1'b0);
    chk(pinOut, coreOut, "sample pins");
    chk(pinOutEn, coreOutEn, "sample enables");
    loadIr(`INS_EXTEST);
    chk(pinOut, 4'ha, "extest preload");
    chk(pinOutEn, 4'hf, "extest enables");
    pinIn = 4'h5;
    coreOut = 4'h6;
    ctrl.scan(1'b0, 8, 32'h3c, dout);
    chk(dout[3:0], pinIn, "extest inputs");
    ctrl.upd(1'b0);
    chk(pinOut, 4'h3, "extest drive");
    $display("test boundary done");
    loadIr(`INS_CLAMP);
    byp();
    chk(pinOut, 4'h3, "clamp pins");
    chk(pinOutEn, 4'hf, "clamp enables");
    loadIr(`INS_HIGHZ);
    byp();
    chk(pinOutEn, 4'h0, "highz enables");
    loadIr(`INS_BYPASS);
    coreOut = 4'hb;
    coreOutEn = 4'h9;
    byp();
    chk(pinOut, coreOut, "bypass pins");
    chk(pinOutEn, coreOutEn, "bypass enables");
    $display("test bypass done");
    loadIr(`INS_OFS_RD);
    k = nStb;
    ctrl.scan(1'b0, 32, 32'h0, dout);
    chk(dout, ofsCur, "offset read");
    ctrl.upd(1'b0);
    loadIr(`INS_OFS_WR);
    ofsCur = 32'h0055_7700;
    ctrl.scan(1'b0, 32, 32'h00c3_0077, dout);
    chk(dout, ofsCur, "offset capture on write");
    ctrl.upd(1'b0);
    chk(ofsWrData, 32'h00c3_0077, "offset write");
    chk(nStb - k, 1, "one write strobe");
    $display("test offsets done");
    loadIr(`INS_EXTEST);
    ctrl.tapReset();
    curIr = `INS_IDCODE;
    chk(instrCur, `INS_IDCODE, "tms reset instr");
    chk(pinOutEn, coreOutEn, "tms reset pins");
    loadIr(`INS_HIGHZ);
    ctrl.rst(1'b0);
    repeat (4) @(posedge clock);
    #1;
    ctrl.rst(1'b1);
    curIr = `INS_IDCODE;
    chk(instrCur, `INS_IDCODE, "trst instr");
    chk(pinOutEn, coreOutEn, "trst pins");
    ctrl.scan(1'b0, 32, 32'h0, dout);
    chk(dout, {VER, PART, MAKR, 1'b1}, "id after trst");
    ctrl.upd(1'b0);
    chk(tdoEn, 1'b0, "tdo idle");
    $display("test resets done");
    print_verdict();
  end
endmodule
